// file: ctc_card_model.sv
// Purpose: card side, ETU strobe and start bits
// Assumes: line idles high through its pull-up
// Notes: each start bit holds the line low one ETU
`timescale 1ns/10ps
`default_nettype none
module ctc_card_model #(
  parameter int ETU_CYC = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic etu_tick,
  output logic card_io
);
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [7:0] low_q;
  logic [7:0] low_d;
  always_comb
  begin
    div_d = (div_q == 8'(ETU_CYC - 1)) ? 8'h00 : div_q + 8'h01;
    low_d = start ? 8'(ETU_CYC) : (low_q != 8'h00 ? low_q - 8'h01 : 8'h00);
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 8'h00;
      low_q <= 8'h00;
    end
    else
    begin
      div_q <= div_d;
      low_q <= low_d;
    end
  end
  assign etu_tick = div_q == 8'(ETU_CYC - 1);
  assign card_io = low_q == 8'h00;
endmodule
`default_nettype wire

// file: ctc_pkg.sv
// Purpose: shared constants and types for the card time-out counter
// Assumes: one core clock, APB register access
// Notes: counter stages tick once per ETU strobe
package ctc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_MID = 8'h08;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam int STATUS_SHORT_BIT = 0;
  localparam int STATUS_LONG_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ************************************************************
  // configuration codes
  // ************************************************************
  localparam logic [7:0] CFG_STOP = 8'h00;
  localparam logic [7:0] CFG_05 = 8'h05;
  localparam logic [7:0] CFG_61 = 8'h61;
  localparam logic [7:0] CFG_65 = 8'h65;
  localparam logic [7:0] CFG_68 = 8'h68;
  localparam logic [7:0] CFG_71 = 8'h71;
  localparam logic [7:0] CFG_75 = 8'h75;
  localparam logic [7:0] CFG_7C = 8'h7C;
  localparam logic [7:0] CFG_85 = 8'h85;
  localparam logic [7:0] CFG_E5 = 8'hE5;
  localparam logic [7:0] CFG_F1 = 8'hF1;
  localparam logic [7:0] CFG_F5 = 8'hF5;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int GUARD_ETU = 12;
  localparam logic [3:0] GUARD_LAST = 4'(GUARD_ETU - 1);

  typedef struct packed {
    logic c1_keep;
    logic c1_sb;
    logic w16_now;
    logic w16_sb;
    logic w24_now;
    logic w24_sb;
    logic guard1;
    logic guard16;
  } ctc_mode_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ctc_apb_req_t;

  // decode of the configuration byte; unlisted codes behave as stop
  function automatic ctc_mode_t ctc_decode(input logic [7:0] cfg);
    ctc_mode_t m;
    m = '0;
    unique case (cfg)
      CFG_05: m.c1_keep = 1'b1;
      CFG_61: m.w16_now = 1'b1;
      CFG_65:
      begin
        m.c1_sb = 1'b1;
        m.w16_now = 1'b1;
      end
      CFG_68: m.w24_now = 1'b1;
      CFG_71: m.w16_sb = 1'b1;
      CFG_75:
      begin
        m.c1_sb = 1'b1;
        m.w16_sb = 1'b1;
      end
      CFG_7C: m.w24_sb = 1'b1;
      CFG_85:
      begin
        m.c1_keep = 1'b1;
        m.guard1 = 1'b1;
        m.guard16 = 1'b1;
      end
      CFG_E5:
      begin
        m.c1_sb = 1'b1;
        m.w16_now = 1'b1;
        m.guard1 = 1'b1;
      end
      CFG_F1:
      begin
        m.w16_sb = 1'b1;
        m.guard16 = 1'b1;
      end
      CFG_F5:
      begin
        m.c1_sb = 1'b1;
        m.w16_sb = 1'b1;
        m.guard1 = 1'b1;
        m.guard16 = 1'b1;
      end
      default: m = '0;
    endcase
    return m;
  endfunction

endpackage

// file: ctc_stage.sv
// Purpose: loadable down-counting stage of the time-out counter
// Assumes: load has priority over decrement
// Notes: wraps below zero, borrow chaining done by the caller
`timescale 1ns/10ps
`default_nettype none
module ctc_stage #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic dec,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // ************************************************************
  // next count
  // ************************************************************
  always_comb
  begin
    count_d = count_q;
    if (load)
    begin
      count_d = load_val;
    end
    else if (dec)
    begin
      count_d = count_q - WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule
`default_nettype wire

// file: ctc_timeout_counter.sv
// Purpose: 24-bit ETU time-out counter of the card reader, APB slave
// Assumes: ETU_TICK one-cycle strobe, CARD_IO already synchronised
// Notes: no wait state, PREADY is registered from the setup phase
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - 75h: 8-bit auto-reload from first start bit
// - 8-bit terminal: pulse, short flag, reload again
// - 75h: 16-bit loads each start bit
// - mid/high rewrite used at next start bit
// - writing 00h stops all counters
// - 7Ch: 24-bit chain reloads each start bit
// - 24-bit reload change used at next start
// - 85h: as 05h, stop after 12 ETU
// - E5h: as 65h, 8-bit stops at 12 ETU
// - F1h: as 71h, 16-bit stops at 12 ETU
// - F5h: as 75h, both stop at 12 ETU
// - 05h: 16-bit stopped, 8-bit keeps running
// - 65h: 16-bit starts at configuration write
// - 71h: 8-bit stopped, 16-bit start-bit retriggered
// - 16-bit terminal: pulse and long flag
module ctc_timeout_counter (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ETU_TICK,
  input wire logic CARD_IO,
  output logic SHORT_TIMEOUT_IRQ,
  output logic LONG_TIMEOUT_IRQ,
  output logic SHORT_TIMEOUT_FLAG,
  output logic LONG_TIMEOUT_FLAG
);

  // ************************************************************
  // declarations
  // ************************************************************
  ctc_pkg::ctc_apb_req_t req;
  ctc_pkg::ctc_mode_t mode_q, mode_d;
  logic [7:0] timeout_config_q, timeout_config_d;
  logic [7:0] reload_low_byte_q, reload_low_byte_d;
  logic [7:0] reload_mid_byte_q, reload_mid_byte_d;
  logic [7:0] reload_high_byte_q, reload_high_byte_d;
  logic short_flag_q, short_flag_d;
  logic long_flag_q, long_flag_d;
  logic short_irq_q, short_irq_d;
  logic long_irq_q, long_irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic run1_q, run1_d;
  logic run16_q, run16_d;
  logic run24_q, run24_d;
  logic arm1_q, arm1_d;
  logic guard_arm_q, guard_arm_d;
  logic guard_on_q, guard_on_d;
  logic [3:0] guard_cnt_q, guard_cnt_d;
  logic io_prev_q;
  logic start_bit;
  logic access;
  logic cfg_wr;
  logic mapped;
  logic lo_load, lo_dec, hi_load, hi_dec;
  logic [7:0] lo_val, lo_cnt;
  logic [15:0] hi_val, hi_cnt;
  logic short_tc, long_tc;
  logic guard_end;

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign access = req.sel && req.enable && pready_q;
  assign cfg_wr = access && req.write && (req.addr == ctc_pkg::ADDR_CONFIG);
  assign start_bit = io_prev_q && !CARD_IO;
  assign guard_end = guard_on_q && ETU_TICK && (guard_cnt_q == ctc_pkg::GUARD_LAST);

  // ************************************************************
  // counter stages
  // ************************************************************
  ctc_stage #(.WIDTH(8)) u_stage_low (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .load(lo_load),
    .load_val(lo_val),
    .dec(lo_dec),
    .count(lo_cnt)
  );

  ctc_stage #(.WIDTH(16)) u_stage_wide (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .load(hi_load),
    .load_val(hi_val),
    .dec(hi_dec),
    .count(hi_cnt)
  );

  // ************************************************************
  // counter control
  // ************************************************************
  always_comb
  begin
    mode_d = mode_q;
    run1_d = run1_q;
    run16_d = run16_q;
    run24_d = run24_q;
    arm1_d = arm1_q;
    guard_arm_d = guard_arm_q;
    guard_on_d = guard_on_q;
    guard_cnt_d = guard_cnt_q;
    lo_load = 1'b0;
    lo_dec = 1'b0;
    hi_load = 1'b0;
    hi_dec = 1'b0;
    lo_val = reload_low_byte_q;
    hi_val = {reload_high_byte_q, reload_mid_byte_q};
    short_tc = 1'b0;
    long_tc = 1'b0;
    // 8-bit auto-reload stage
    if (run1_q && ETU_TICK)
    begin
      if (lo_cnt == 8'h01)
      begin
        short_tc = 1'b1;
        lo_load = 1'b1;
      end
      else
      begin
        lo_dec = 1'b1;
      end
    end
    // 16-bit stage, one shot per start
    if (run16_q && ETU_TICK)
    begin
      if (hi_cnt == 16'h0001)
      begin
        long_tc = 1'b1;
        run16_d = 1'b0;
      end
      else
      begin
        hi_dec = 1'b1;
      end
    end
    // 24-bit chain, borrow from low into wide stage
    if (run24_q && ETU_TICK)
    begin
      if (hi_cnt == 16'h0000 && lo_cnt == 8'h01)
      begin
        long_tc = 1'b1;
        run24_d = 1'b0;
      end
      lo_dec = 1'b1;
      hi_dec = (lo_cnt == 8'h00);
    end
    // start bits on the card line
    if (start_bit)
    begin
      if (arm1_q)
      begin
        arm1_d = 1'b0;
        run1_d = 1'b1;
        lo_load = 1'b1;
      end
      if (mode_q.w16_sb)
      begin
        run16_d = 1'b1;
        hi_load = 1'b1;
      end
      if (mode_q.w24_sb)
      begin
        run24_d = 1'b1;
        lo_load = 1'b1;
        hi_load = 1'b1;
      end
      if (guard_arm_q)
      begin
        guard_arm_d = 1'b0;
        guard_on_d = 1'b1;
        guard_cnt_d = '0;
      end
    end
    // twelve ETU guard after the first start bit
    if (guard_on_q && ETU_TICK)
    begin
      guard_cnt_d = guard_cnt_q + 4'h1;
    end
    if (guard_end)
    begin
      guard_on_d = 1'b0;
      if (mode_q.guard1)
      begin
        run1_d = 1'b0;
        arm1_d = 1'b0;
      end
      if (mode_q.guard16)
      begin
        run16_d = 1'b0;
        mode_d.w16_sb = 1'b0;
      end
    end
    // configuration write overrides the control above, except this cycle's 8-bit decrement and terminal pulses
    if (cfg_wr)
    begin
      mode_d = ctc_pkg::ctc_decode(req.wdata[7:0]);
      run1_d = mode_d.c1_keep ? run1_q : 1'b0;
      arm1_d = mode_d.c1_keep ? arm1_q : mode_d.c1_sb;
      run16_d = mode_d.w16_now;
      run24_d = mode_d.w24_now;
      hi_load = mode_d.w16_now || mode_d.w24_now;
      lo_load = mode_d.w24_now || (mode_d.c1_keep && short_tc);
      hi_dec = 1'b0;
      lo_dec = lo_dec && !lo_load;
      guard_arm_d = mode_d.guard1 || mode_d.guard16;
      guard_on_d = 1'b0;
      guard_cnt_d = '0;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  always_comb
  begin
    timeout_config_d = timeout_config_q;
    reload_low_byte_d = reload_low_byte_q;
    reload_mid_byte_d = reload_mid_byte_q;
    reload_high_byte_d = reload_high_byte_q;
    short_flag_d = short_flag_q;
    long_flag_d = long_flag_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    pready_d = 1'b0;
    mapped = 1'b1;
    unique case (req.addr)
      ctc_pkg::ADDR_CONFIG: prdata_d = {24'h000000, timeout_config_q};
      ctc_pkg::ADDR_RELOAD_LOW: prdata_d = {24'h000000, reload_low_byte_q};
      ctc_pkg::ADDR_RELOAD_MID: prdata_d = {24'h000000, reload_mid_byte_q};
      ctc_pkg::ADDR_RELOAD_HIGH: prdata_d = {24'h000000, reload_high_byte_q};
      ctc_pkg::ADDR_STATUS: prdata_d = {30'h00000000, long_flag_q, short_flag_q};
      ctc_pkg::ADDR_COUNT: prdata_d = {8'h00, hi_cnt, lo_cnt};
      default:
      begin
        prdata_d = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
    if (req.sel && !req.enable)
    begin
      pready_d = 1'b1;
      pslverr_d = !mapped;
    end
    else if (!access)
    begin
      prdata_d = prdata_q;
    end
    if (access && req.write)
    begin
      unique case (req.addr)
        ctc_pkg::ADDR_CONFIG: timeout_config_d = req.wdata[7:0];
        ctc_pkg::ADDR_RELOAD_LOW: reload_low_byte_d = req.wdata[7:0];
        ctc_pkg::ADDR_RELOAD_MID: reload_mid_byte_d = req.wdata[7:0];
        ctc_pkg::ADDR_RELOAD_HIGH: reload_high_byte_d = req.wdata[7:0];
        ctc_pkg::ADDR_STATUS:
        begin
          if (req.wdata[ctc_pkg::STATUS_SHORT_BIT])
          begin
            short_flag_d = 1'b0;
          end
          if (req.wdata[ctc_pkg::STATUS_LONG_BIT])
          begin
            long_flag_d = 1'b0;
          end
        end
        default: pslverr_d = pslverr_q;
      endcase
    end
    // hardware set wins over a clear in the same cycle
    if (short_tc)
    begin
      short_flag_d = 1'b1;
    end
    if (long_tc)
    begin
      long_flag_d = 1'b1;
    end
    short_irq_d = short_tc;
    long_irq_d = long_tc;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_q <= '0;
      run1_q <= 1'b0;
      run16_q <= 1'b0;
      run24_q <= 1'b0;
      arm1_q <= 1'b0;
      guard_arm_q <= 1'b0;
      guard_on_q <= 1'b0;
      guard_cnt_q <= '0;
      io_prev_q <= 1'b1;
      timeout_config_q <= ctc_pkg::RESET_BYTE;
      reload_low_byte_q <= ctc_pkg::RESET_BYTE;
      reload_mid_byte_q <= ctc_pkg::RESET_BYTE;
      reload_high_byte_q <= ctc_pkg::RESET_BYTE;
      short_flag_q <= 1'b0;
      long_flag_q <= 1'b0;
      short_irq_q <= 1'b0;
      long_irq_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      run1_q <= run1_d;
      run16_q <= run16_d;
      run24_q <= run24_d;
      arm1_q <= arm1_d;
      guard_arm_q <= guard_arm_d;
      guard_on_q <= guard_on_d;
      guard_cnt_q <= guard_cnt_d;
      io_prev_q <= CARD_IO;
      timeout_config_q <= timeout_config_d;
      reload_low_byte_q <= reload_low_byte_d;
      reload_mid_byte_q <= reload_mid_byte_d;
      reload_high_byte_q <= reload_high_byte_d;
      short_flag_q <= short_flag_d;
      long_flag_q <= long_flag_d;
      short_irq_q <= short_irq_d;
      long_irq_q <= long_irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign SHORT_TIMEOUT_IRQ = short_irq_q;
  assign LONG_TIMEOUT_IRQ = long_irq_q;
  assign SHORT_TIMEOUT_FLAG = short_flag_q;
  assign LONG_TIMEOUT_FLAG = long_flag_q;

endmodule
`default_nettype wire

// file: ctc_timeout_counter_properties.sv
// Purpose: port checks of the time-out counter
// Assumes: ETU_TICK pulses at least two cycles apart
// Notes: bound to the top module
`timescale 1ns/10ps
`default_nettype none
module ctc_timeout_counter_properties (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic ETU_TICK,
  input wire logic CARD_IO,
  input wire logic SHORT_TIMEOUT_IRQ,
  input wire logic LONG_TIMEOUT_IRQ,
  input wire logic SHORT_TIMEOUT_FLAG,
  input wire logic LONG_TIMEOUT_FLAG
);
  logic cfg_wr;
  logic irq;
  assign cfg_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == ctc_pkg::ADDR_CONFIG;
  assign irq = SHORT_TIMEOUT_IRQ || LONG_TIMEOUT_IRQ;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ****
  // properties
  // ****
  property p_ready;
    PSEL && !PENABLE |=> PREADY;
  endproperty
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  property p_short_tick;
    SHORT_TIMEOUT_IRQ |-> $past(ETU_TICK) || $past(ETU_TICK, 2);
  endproperty
  property p_short_pulse;
    SHORT_TIMEOUT_IRQ |=> !SHORT_TIMEOUT_IRQ;
  endproperty
  property p_short_flag;
    SHORT_TIMEOUT_IRQ |-> ##[0:1] SHORT_TIMEOUT_FLAG;
  endproperty
  property p_long_flag;
    LONG_TIMEOUT_IRQ |-> ##[0:1] LONG_TIMEOUT_FLAG;
  endproperty
  property p_stop;
    cfg_wr && PWDATA[7:0] == ctc_pkg::CFG_STOP |=> ##2 !irq [*8];
  endproperty
  property p_cfg05;
    cfg_wr && PWDATA[7:0] == ctc_pkg::CFG_05 |=> ##2 !LONG_TIMEOUT_IRQ [*8];
  endproperty
  property p_cfg75;
    cfg_wr && PWDATA[7:0] == ctc_pkg::CFG_75 ##1 CARD_IO [*6] |-> !irq;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  a_short_tick: assert property (p_short_tick) else $error("short pulse without tick");
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse too long");
  a_short_flag: assert property (p_short_flag) else $error("short flag not set");
  a_long_flag: assert property (p_long_flag) else $error("long flag not set");
  a_stop: assert property (p_stop) else $error("pulse after stop");
  a_cfg05: assert property (p_cfg05) else $error("wide count in 05");
  a_cfg75: assert property (p_cfg75) else $error("pulse before start bit");
  c_short: cover property (SHORT_TIMEOUT_IRQ);
  c_long: cover property (LONG_TIMEOUT_IRQ);
  c_cfg: cover property (cfg_wr);
endmodule
bind ctc_timeout_counter ctc_timeout_counter_properties chk_u (
  .CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .ETU_TICK,
  .CARD_IO, .SHORT_TIMEOUT_IRQ, .LONG_TIMEOUT_IRQ, .SHORT_TIMEOUT_FLAG, .LONG_TIMEOUT_FLAG);
`default_nettype wire

// file: ctc_timeout_counter_tb.sv
// Purpose: self-checking bench of the time-out counter
// Assumes: one ETU is four core cycles
// Notes: table of modes, pulse counts per row
`timescale 1ns/10ps
`default_nettype none
module ctc_timeout_counter_tb;
  typedef struct packed {
    logic [7:0] cfg, low, mid, high, nlow, starts, ticks, es, el;
  } ctc_row_t;
  logic clk;
  logic rst_n;
  logic start;
  ctc_pkg::ctc_apb_req_t req;
  logic [31:0] prdata;
  logic pready, pslverr, etu, cio, sirq, lirq, sflag, lflag;
  logic [32:0] expq[$];
  logic [7:0] n8;
  int fail_count, checks, ns, nl, b_s, b_l;
  ctc_row_t rows[10];
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ctc_card_model card_u (.clk(clk), .rst_n(rst_n), .start(start), .etu_tick(etu),
    .card_io(cio));
  ctc_timeout_counter dut_u (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(req.sel),
    .PENABLE(req.enable), .PWRITE(req.write), .PADDR(req.addr), .PWDATA(req.wdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ETU_TICK(etu), .CARD_IO(cio),
    .SHORT_TIMEOUT_IRQ(sirq), .LONG_TIMEOUT_IRQ(lirq), .SHORT_TIMEOUT_FLAG(sflag),
    .LONG_TIMEOUT_FLAG(lflag));
  // ****
  // tasks
  // ****
  task automatic note(input bit ok, input string m);
    checks++;
    if (!ok)
    begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic chk_rd(input logic [32:0] g, input logic [32:0] e);
    note(g === e, "read data or error flag");
  endtask
  task automatic chk_cnt(input int g, input int e);
    note(g == e, "timeout pulse count");
  endtask
  task automatic chk_flg(input logic [1:0] g, input logic [1:0] e);
    note(g === e, "status flag pins");
  endtask
  task automatic print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: d};
    @(posedge clk);
    req.enable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  always @(posedge clk)
  begin
    if (sirq === 1'b1)
      ns <= ns + 1;
    if (lirq === 1'b1)
      nl <= nl + 1;
    if (req.sel && req.enable && pready === 1'b1 && !req.write && expq.size() > 0)
      chk_rd({pslverr, prdata}, expq.pop_front());
  end
  initial
  begin
    #100000;
    fail_count++;
    print_verdict();
  end
  // ****
  // main sequence
  // ****
  initial
  begin
    req = '0;
    start = 1'b0;
    rst_n = 1'b0;
    void'($urandom(28));
    n8 = 8'(6 + $urandom % 4);
    rows[0] = '{8'h75, n8, 8'h00, 8'h01, 8'h00, 8'h01, 8'(3 * n8 + n8 / 2), 8'h03, 8'h00};
    rows[1] = '{8'h71, 8'h01, 8'h08, 8'h00, 8'h00, 8'h02, 8'h0C, 8'h00, 8'h02};
    rows[2] = '{8'h7C, 8'h06, 8'h00, 8'h00, 8'h28, 8'h02, 8'h0A, 8'h00, 8'h01};
    rows[3] = '{8'hF5, 8'h05, 8'h14, 8'h00, 8'h00, 8'h01, 8'h1E, 8'h02, 8'h00};
    rows[4] = '{8'hF1, 8'h01, 8'h05, 8'h00, 8'h00, 8'h02, 8'h0F, 8'h00, 8'h01};
    rows[5] = '{8'hE5, 8'h05, 8'h64, 8'h00, 8'h00, 8'h01, 8'h1E, 8'h02, 8'h00};
    rows[6] = '{8'h65, 8'h05, 8'h06, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h01};
    rows[7] = '{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    rows[8] = '{8'h61, 8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h01};
    rows[9] = '{8'h68, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h00, 8'h01};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h18, {1'b1, 32'h0});
    foreach (rows[i])
    begin
      b_s = ns;
      b_l = nl;
      apb(1'b1, 8'h04, {24'h0, rows[i].low});
      apb(1'b1, 8'h08, {24'h0, rows[i].mid});
      apb(1'b1, 8'h0C, {24'h0, rows[i].high});
      apb(1'b1, 8'h00, {24'h0, rows[i].cfg});
      repeat (8) @(posedge clk);
      for (int s = 0; s < 1 || s < int'(rows[i].starts); s++)
      begin
        if (s < int'(rows[i].starts))
          pulse();
        if (s == 0 && rows[i].nlow != 8'h00)
        begin
          repeat (8) @(posedge clk);
          apb(1'b1, 8'h04, {24'h0, rows[i].nlow});
        end
        repeat (4 * int'(rows[i].ticks)) @(posedge clk);
      end
      apb(1'b1, 8'h00, 32'h0);
      repeat (40) @(posedge clk);
      chk_cnt(ns - b_s, int'(rows[i].es));
      chk_cnt(nl - b_l, int'(rows[i].el));
    end
    // 85h: running 8-bit stage kept, stopped 12 ETU after next start bit
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h00, {24'h0, ctc_pkg::CFG_75});
    pulse();
    repeat (40) @(posedge clk);
    apb(1'b1, 8'h00, {24'h0, ctc_pkg::CFG_85});
    repeat (8) @(posedge clk);
    pulse();
    repeat (3) @(posedge clk);
    b_s = ns;
    repeat (80) @(posedge clk);
    chk_cnt(ns - b_s, 4);
    rd(8'h10, {1'b0, 32'h3});
    chk_flg({lflag, sflag}, 2'b11);
    apb(1'b1, 8'h10, 32'h3);
    rd(8'h10, 33'h0);
    chk_flg({lflag, sflag}, 2'b00);
    print_verdict();
  end
endmodule
`default_nettype wire
